// file: rtl/rtccs_pkg.sv
// Shared constants of the clock-calendar control and status block
package rtccs_pkg;

   // Register indices; the bus address is four times the index
   localparam logic [7:0] REG_A_IDX  = 8'h0A;
   localparam logic [7:0] REG_B_IDX  = 8'h0B;
   localparam logic [7:0] REG_C_IDX  = 8'h0C;
   localparam logic [7:0] REG_D_IDX  = 8'h0D;
   localparam logic [7:0] REG_A_ADDR = {REG_A_IDX[5:0], 2'h0};
   localparam logic [7:0] REG_B_ADDR = {REG_B_IDX[5:0], 2'h0};
   localparam logic [7:0] REG_C_ADDR = {REG_C_IDX[5:0], 2'h0};
   localparam logic [7:0] REG_D_ADDR = {REG_D_IDX[5:0], 2'h0};

   // Field positions
   localparam int A_UIP_BIT  = 7;
   localparam int A_OSC_LSB  = 4;
   localparam int A_RATE_LSB = 0;
   localparam int B_UTI_BIT  = 7;
   localparam int B_PIE_BIT  = 6;
   localparam int B_AIE_BIT  = 5;
   localparam int B_UIE_BIT  = 4;
   localparam int B_SPR_BIT  = 3;
   localparam int B_BIN_BIT  = 2;
   localparam int B_H24_BIT  = 1;
   localparam int B_DST_BIT  = 0;

   // Oscillator control encodings
   localparam logic [2:0] OSC_RUN_DIV     = 3'h2;
   localparam logic [2:0] OSC_RUN_DIV_ALT = 3'h3;
   localparam logic [1:0] OSC_ONLY_TOP    = 2'h3;

   // Values after reset
   localparam logic [2:0] RST_OSC  = 3'h0;
   localparam logic [3:0] RST_RATE = 4'h0;
   localparam logic       RST_BIT  = 1'b0;

   // Timing: clock rates, times and their lengths in crystal ticks
   localparam int CLK_HZ_DFLT     = 40000000;
   localparam int CLK_PERIOD_NS   = 25;
   localparam int OSC_HZ          = 32768;
   localparam int SEC_TICKS       = 32768;
   localparam int FIRST_UPD_MS    = 500;
   localparam int FIRST_UPD_TICKS = FIRST_UPD_MS * OSC_HZ / 1000;
   localparam int BUC_TIME_US     = 244;
   localparam int BUC_TICKS       = (BUC_TIME_US * OSC_HZ + 999999) / 1000000;
   localparam int UC_TIME_US      = 976;
   localparam int UC_TICKS        = UC_TIME_US * OSC_HZ / 1000000;
   localparam int GAP_TIME_MS     = 999;
   localparam int GAP_TICKS       = (GAP_TIME_MS * OSC_HZ + 999) / 1000;
   localparam int CSR_TIME_MS     = 200;
   localparam int CSR_TICKS_DFLT  = (CSR_TIME_MS * OSC_HZ + 999) / 1000;
   localparam int UPD_START       = SEC_TICKS - UC_TICKS;
   localparam int UIP_START       = UPD_START - BUC_TICKS;

endpackage : rtccs_pkg

// file: rtl/rtccs_top.sv
// Control and status registers of the clock-calendar core, APB slave
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module rtccs_top #(
   parameter int CLK_HZ    = rtccs_pkg::CLK_HZ_DFLT,
   parameter int CSR_TICKS = rtccs_pkg::CSR_TICKS_DFLT
) (
   input  wire logic        REF_CLK_I,
   input  wire logic        RST_B_I,
   input  wire logic        POR_B_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output var  logic [31:0] PRDATA_O,
   output var  logic        PREADY_O,
   output var  logic        PSLVERR_O,
   input  wire logic        EXT_STORAGE_SEL_I,
   input  wire logic        POWER_FAIL_I,
   input  wire logic        BACKUP_VALID_I,
   input  wire logic        ALARM_MATCH_I,
   input  wire logic        DST_OCT_DAY_I,
   input  wire logic        DST_APR_DAY_I,
   input  wire logic        AT_015959_I,
   output var  logic        IRQ_N_O,
   output var  logic        IRQ_N_OE_O,
   output var  logic        OSC_RUN_O,
   output var  logic        DIV_RUN_O,
   output var  logic        UPDATE_BUSY_O,
   output var  logic        TIME_COPY_O,
   output var  logic        HOUR_24_O,
   output var  logic        BINARY_FMT_O,
   output var  logic        DST_BACK_O,
   output var  logic        DST_FWD_O,
   output var  logic        WRITE_PROT_O
);

   localparam int CSR_W = $clog2(CSR_TICKS + 1);
   if (CLK_HZ < 2 * rtccs_pkg::OSC_HZ) begin : g_bad_clk
      $error("Clock too slow to derive crystal ticks");
   end
   if (CSR_TICKS < 1) begin : g_bad_csr
      $error("Recovery interval must be at least one tick");
   end
   if (rtccs_pkg::UPD_START < rtccs_pkg::GAP_TICKS) begin : g_bad_gap
      $error("Update cycle too long for the post-update gap");
   end
   function automatic logic [14:0] rate_mask(input logic [3:0] rs);
      logic [15:0] one_hot;
      one_hot = 16'h0001 << (rs - 4'h1);
      case (rs)
         4'h0:    rate_mask = 15'h0000;
         4'h1:    rate_mask = 15'h007F;
         4'h2:    rate_mask = 15'h00FF;
         default: rate_mask = 15'(one_hot - 16'h0001);
      endcase
   endfunction : rate_mask

   wire logic        rst_any;
   logic [31:0]      acc_q;
   wire logic [31:0] acc_sum;
   wire logic [31:0] acc_d;
   wire logic        tick_raw;
   wire logic        tick;
   logic [2:0]       osc_q;
   logic [3:0]       rate_q;
   logic             uti_q, pie_q, aie_q, uie_q, spr_q, bin_q, h24_q, dst_q;
   logic             pf_q, af_q, uf_q, irq_request_flag_q, uip_q, valid_q, fall_done_q;
   logic [14:0]      div_cnt_q;
   logic [14:0]      div_cnt_d;
   logic [CSR_W-1:0] recov_q;
   logic [CSR_W-1:0] recov_d;
   logic             pready_q, pslverr_q;
   logic [31:0]      prdata_q;
   logic             irq_oe_q, irq_n_q, osc_run_q, div_run_q, busy_q, copy_q, back_q, fwd_q, wp_q;
   assign rst_any = !RST_B_I || !POR_B_I;
   // APB decode, one wait state on every access
   wire logic       acc_phase, take, done, own, mapped;
   wire logic       hit_a, hit_b, hit_c, hit_d;
   wire logic       wp, wr_ok, wr_a, wr_b, rd_c;
   wire logic [7:0] reg_a_val, reg_b_val, reg_c_val, reg_d_val, rd_byte;
   assign acc_phase = PSEL_I && PENABLE_I;
   assign take      = acc_phase && !pready_q;
   assign done      = acc_phase && pready_q;
   assign own       = !EXT_STORAGE_SEL_I;
   assign hit_a     = PADDR_I == rtccs_pkg::REG_A_ADDR;
   assign hit_b     = PADDR_I == rtccs_pkg::REG_B_ADDR;
   assign hit_c     = PADDR_I == rtccs_pkg::REG_C_ADDR;
   assign hit_d     = PADDR_I == rtccs_pkg::REG_D_ADDR;
   assign mapped    = hit_a || hit_b || hit_c || hit_d;
   assign wp        = POWER_FAIL_I || (recov_q != '0);
   assign wr_ok     = done && PWRITE_I && own && !wp;
   assign wr_a      = wr_ok && hit_a;
   assign wr_b      = wr_ok && hit_b;
   // Clear at the capture edge so no event slips between sample and clear
   assign rd_c      = take && !PWRITE_I && own && hit_c;
   assign reg_a_val = {uip_q, osc_q, rate_q};
   assign reg_b_val = {uti_q, pie_q, aie_q, uie_q, spr_q, bin_q, h24_q, dst_q};
   assign reg_c_val = {irq_request_flag_q, pf_q, af_q, uf_q, 4'h0};
   assign reg_d_val = {valid_q, 7'h00};
   assign rd_byte   = !own  ? 8'h00 :
                      hit_a ? reg_a_val :
                      hit_b ? reg_b_val :
                      hit_c ? reg_c_val :
                      hit_d ? reg_d_val : 8'h00;

   always_ff @(posedge REF_CLK_I) begin
      if (rst_any) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else begin
         pready_q  <= take;
         pslverr_q <= take && own && !mapped;
         if (take) begin
            prdata_q <= PWRITE_I ? 32'h00000000 : {24'h000000, rd_byte};
         end
      end
   end

   // Crystal tick from the reference clock, exact on average
   assign acc_sum  = acc_q + 32'(rtccs_pkg::OSC_HZ);
   assign tick_raw = acc_sum >= 32'(CLK_HZ);
   assign acc_d    = tick_raw ? acc_sum - 32'(CLK_HZ) : acc_sum;
   always_ff @(posedge REF_CLK_I) begin
      if (!POR_B_I) begin
         acc_q <= 32'h00000000;
      end else begin
         acc_q <= acc_d;
      end
   end

   // Oscillator and divider control
   wire logic        div_on, osc_on, div_step, start_half, upd_end, in_upd, uip_win, per_evt;
   wire logic [14:0] div_nxt;
   assign div_on   = (osc_q == rtccs_pkg::OSC_RUN_DIV) || (osc_q == rtccs_pkg::OSC_RUN_DIV_ALT);
   assign osc_on   = div_on || (osc_q[2:1] == rtccs_pkg::OSC_ONLY_TOP);
   assign tick     = tick_raw && osc_on;
   assign div_step = tick && div_on;
   assign div_nxt  = div_cnt_q + 15'h0001;
   assign start_half = wr_a && (PWDATA_I[rtccs_pkg::A_OSC_LSB +: 3] == rtccs_pkg::OSC_RUN_DIV)
                       && (osc_q != rtccs_pkg::OSC_RUN_DIV);
   assign upd_end  = div_step && (div_cnt_q == 15'(rtccs_pkg::SEC_TICKS - 1));
   // update occupies only the last ticks
   assign in_upd   = div_on && (div_cnt_q >= 15'(rtccs_pkg::UPD_START));
   assign uip_win  = div_on && (div_cnt_q >= 15'(rtccs_pkg::UIP_START));
   assign per_evt  = div_step && (rate_q != 4'h0) && ((div_nxt & rate_mask(rate_q)) == 15'h0000);
   always_comb begin
      div_cnt_d = div_cnt_q;
      if (start_half) begin
         div_cnt_d = 15'(rtccs_pkg::SEC_TICKS - rtccs_pkg::FIRST_UPD_TICKS);
      end else if (!div_on) begin
         div_cnt_d = 15'h0000;
      end else if (div_step) begin
         div_cnt_d = div_nxt;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!POR_B_I) begin
         osc_q     <= rtccs_pkg::RST_OSC;
         rate_q    <= rtccs_pkg::RST_RATE;
         div_cnt_q <= 15'h0000;
      end else begin
         div_cnt_q <= div_cnt_d;
         if (wr_a) begin
            osc_q  <= PWDATA_I[rtccs_pkg::A_OSC_LSB +: 3];
            rate_q <= PWDATA_I[rtccs_pkg::A_RATE_LSB +: 4];
         end
      end
   end

   // Register B
   wire logic uti_d, pie_d, aie_d, uie_d;
   assign uti_d = wr_b ? PWDATA_I[rtccs_pkg::B_UTI_BIT] : uti_q;
   assign pie_d = wr_b ? PWDATA_I[rtccs_pkg::B_PIE_BIT] : pie_q;
   assign aie_d = wr_b ? PWDATA_I[rtccs_pkg::B_AIE_BIT] : aie_q;
   assign uie_d = (wr_b ? PWDATA_I[rtccs_pkg::B_UIE_BIT] : uie_q) && !uti_d;
   always_ff @(posedge REF_CLK_I) begin
      if (rst_any) begin
         pie_q <= rtccs_pkg::RST_BIT;
         aie_q <= rtccs_pkg::RST_BIT;
         uie_q <= rtccs_pkg::RST_BIT;
         spr_q <= rtccs_pkg::RST_BIT;
      end else begin
         pie_q <= pie_d;
         aie_q <= aie_d;
         uie_q <= uie_d;
         if (wr_b) begin
            spr_q <= PWDATA_I[rtccs_pkg::B_SPR_BIT];
         end
      end
   end

   // format bits held for the counters
   always_ff @(posedge REF_CLK_I) begin
      if (!POR_B_I) begin
         uti_q <= rtccs_pkg::RST_BIT;
         bin_q <= rtccs_pkg::RST_BIT;
         h24_q <= rtccs_pkg::RST_BIT;
         dst_q <= rtccs_pkg::RST_BIT;
      end else begin
         uti_q <= uti_d;
         if (wr_b) begin
            bin_q <= PWDATA_I[rtccs_pkg::B_BIN_BIT];
            h24_q <= PWDATA_I[rtccs_pkg::B_H24_BIT];
            dst_q <= PWDATA_I[rtccs_pkg::B_DST_BIT];
         end
      end
   end

   // Event flags; a set in the clearing cycle wins
   wire logic pf_d, af_d, uf_d, irq_request_flag_d;
   assign uf_d   = upd_end || (uf_q && !rd_c);
   assign af_d   = (upd_end && ALARM_MATCH_I) || (af_q && !rd_c);
   assign pf_d   = per_evt || (pf_q && !rd_c);
   assign irq_request_flag_d = (irq_request_flag_q && !rd_c) || (pf_d && pie_d) || (af_d && aie_d) || (uf_d && uie_d);
   always_ff @(posedge REF_CLK_I) begin
      if (rst_any) begin
         pf_q   <= 1'b0;
         af_q   <= 1'b0;
         uf_q   <= 1'b0;
         irq_request_flag_q <= 1'b0;
      end else begin
         pf_q   <= pf_d;
         af_q   <= af_d;
         uf_q   <= uf_d;
         irq_request_flag_q <= irq_request_flag_d;
      end
   end

   always_comb begin
      recov_d = recov_q;
      if (POWER_FAIL_I) begin
         recov_d = CSR_W'(CSR_TICKS);
      end else if (tick_raw && (recov_q != '0)) begin
         recov_d = recov_q - CSR_W'(1);
      end
   end

   // Daylight saving; fall back only once per October Sunday
   wire logic fwd_evt, back_evt, fall_done_d;
   assign fwd_evt     = upd_end && dst_q && DST_APR_DAY_I && AT_015959_I;
   assign back_evt    = upd_end && dst_q && DST_OCT_DAY_I && AT_015959_I && !fall_done_q;
   assign fall_done_d = DST_OCT_DAY_I && (fall_done_q || back_evt);
   always_ff @(posedge REF_CLK_I) begin
      if (!POR_B_I) begin
         recov_q     <= '0;
         uip_q       <= 1'b0;
         valid_q     <= 1'b0;
         fall_done_q <= 1'b0;
      end else begin
         recov_q     <= recov_d;
         // window ahead of update, off under inhibit
         uip_q       <= uip_win && !uti_d;
         valid_q     <= BACKUP_VALID_I;
         fall_done_q <= fall_done_d;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (rst_any) begin
         irq_oe_q  <= 1'b0;
         irq_n_q   <= 1'b1;
         osc_run_q <= 1'b0;
         div_run_q <= 1'b0;
         busy_q    <= 1'b0;
         copy_q    <= 1'b0;
         back_q    <= 1'b0;
         fwd_q     <= 1'b0;
         wp_q      <= 1'b1;
      end else begin
         irq_oe_q  <= irq_request_flag_d;
         irq_n_q   <= !irq_request_flag_d;
         osc_run_q <= osc_on;
         div_run_q <= div_on;
         busy_q    <= in_upd;
         copy_q    <= upd_end && !uti_q;
         back_q    <= back_evt;
         fwd_q     <= fwd_evt;
         wp_q      <= POWER_FAIL_I || (recov_d != '0);
      end
   end

   assign PRDATA_O      = prdata_q;
   assign PREADY_O      = pready_q;
   assign PSLVERR_O     = pslverr_q;
   assign IRQ_N_O       = irq_n_q;
   assign IRQ_N_OE_O    = irq_oe_q;
   assign OSC_RUN_O     = osc_run_q;
   assign DIV_RUN_O     = div_run_q;
   assign UPDATE_BUSY_O = busy_q;
   assign TIME_COPY_O   = copy_q;
   assign HOUR_24_O     = h24_q;
   assign BINARY_FMT_O  = bin_q;
   assign DST_BACK_O    = back_q;
   assign DST_FWD_O     = fwd_q;
   assign WRITE_PROT_O  = wp_q;

   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (rst_any);
   property p_uip_inhibit;
      uti_q && $past(uti_q) |-> !uip_q;
   endproperty
   a_uip_inhibit: assert property (p_uip_inhibit) else $error("UPDATE_IN_PROGRESS_FLAG set under inhibit");
   property p_uie_inhibit;
      uti_q |-> !uie_q;
   endproperty
   a_uie_inhibit: assert property (p_uie_inhibit) else $error("UPDATE_IRQ_ENABLE left set under inhibit");
   property p_read_clear;
      rd_c && !upd_end && !per_evt |=> !uf_q && !af_q && !pf_q && !irq_request_flag_q;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("Register C read did not clear");
   property p_req_flag;
      (pf_q && pie_q) || (af_q && aie_q) || (uf_q && uie_q) |-> irq_request_flag_q;
   endproperty
   a_req_flag: assert property (p_req_flag) else $error("Enabled event without request");
   property p_irq_pin;
      ##1 (IRQ_N_OE_O == irq_request_flag_q) && (IRQ_N_O == !irq_request_flag_q);
   endproperty
   a_irq_pin: assert property (p_irq_pin) else $error("Interrupt pin disagrees with request");
   property p_wp_block;
      POWER_FAIL_I && done && PWRITE_I && hit_b |=> bin_q == $past(bin_q) && h24_q == $past(h24_q);
   endproperty
   a_wp_block: assert property (p_wp_block) else $error("Write passed during power fail");
   property p_first_update;
      start_half |=> div_cnt_q == 15'(rtccs_pkg::SEC_TICKS - rtccs_pkg::FIRST_UPD_TICKS);
   endproperty
   a_first_update: assert property (p_first_update) else $error("Half-second start not loaded");
   property p_uip_ahead;
      $rose(in_upd) && !$past(uti_q, 2) && !$past(uti_q) |-> uip_q;
   endproperty
   a_uip_ahead: assert property (p_uip_ahead) else $error("Update began with UPDATE_IN_PROGRESS_FLAG clear");
   property p_rate_tap;
      per_evt |-> rate_q != 4'h0 && div_on && (div_nxt[1:0] == 2'h0);
   endproperty
   a_rate_tap: assert property (p_rate_tap) else $error("Periodic event off its tap");
   property p_copy_inhibit;
      TIME_COPY_O |-> !$past(uti_q) && $past(upd_end);
   endproperty
   a_copy_inhibit: assert property (p_copy_inhibit) else $error("Copy under inhibit");
   // Run outputs are reset by a warm reset that keeps the field, so skip that edge
   property p_osc_decode;
      !rst_any |=> DIV_RUN_O == $past(div_on) && (!DIV_RUN_O || OSC_RUN_O);
   endproperty
   a_osc_decode: assert property (p_osc_decode) else $error("Oscillator outputs wrong");
endmodule : rtccs_top

`default_nettype wire

// file: dv/rtccs_host.sv
// Host-side APB master model for the clock-calendar registers
`timescale 1ns/1ps
`default_nettype none
module rtccs_host (
   input  wire logic        clk_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i,
   input  wire logic [31:0] prdata_i,
   output var  logic        psel_o,
   output var  logic        penable_o,
   output var  logic        pwrite_o,
   output var  logic [7:0]  paddr_o,
   output var  logic [31:0] pwdata_o,
   output var  logic        ext_sel_o
);
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h00000000;
      ext_sel_o = 1'b0;
   end

   // Waits for the slave's answer, giving up after 64 cycles
   task automatic xfer(input logic wr, input logic ext, input logic [7:0] adr, input logic [7:0] wd,
                       output logic [31:0] rdat, output logic err);
      int n;
      @(posedge clk_i);
      ext_sel_o <= ext;
      psel_o <= 1'b1;
      pwrite_o <= wr;
      paddr_o <= adr;
      pwdata_o <= {24'h000000, wd};
      @(posedge clk_i);
      penable_o <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_i !== 1'b1 && n < 64);
      rdat = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      ext_sel_o <= 1'b0;
      // Released lines show a fresh pattern, not the old value
      paddr_o <= ~adr;
      pwdata_o <= ~pwdata_o;
   endtask : xfer
endmodule : rtccs_host
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench of the clock-calendar control and status registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int CLK_SIM = 65536;
   localparam int CYC_TK  = CLK_SIM / rtccs_pkg::OSC_HZ;
   logic        clk, rst_b, por_b, psel, pen, pwr, ext, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, seed, rd;
   logic        pfail, bvalid, alarm, oct_day, apr_day, at_0159, er, hit;
   logic        irq_n, irq_oe, osc_run, div_run, busy, tcopy, h24, bin, dst_b, dst_f, wprot;
   logic [7:0]  d;
   int          err_count, check_count, cyc, t0, last0;
   int          rs_list[4] = '{1, 2, 3, 6};

   rtccs_host host_u (.clk_i(clk), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
      .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwdata), .ext_sel_o(ext));

   rtccs_top #(.CLK_HZ(CLK_SIM), .CSR_TICKS(4)) dut_u (.REF_CLK_I(clk), .RST_B_I(rst_b), .POR_B_I(por_b),
      .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_STORAGE_SEL_I(ext),
      .POWER_FAIL_I(pfail), .BACKUP_VALID_I(bvalid), .ALARM_MATCH_I(alarm), .DST_OCT_DAY_I(oct_day),
      .DST_APR_DAY_I(apr_day), .AT_015959_I(at_0159), .IRQ_N_O(irq_n), .IRQ_N_OE_O(irq_oe),
      .OSC_RUN_O(osc_run), .DIV_RUN_O(div_run), .UPDATE_BUSY_O(busy), .TIME_COPY_O(tcopy),
      .HOUR_24_O(h24), .BINARY_FMT_O(bin), .DST_BACK_O(dst_b), .DST_FWD_O(dst_f), .WRITE_PROT_O(wprot));

   always #12.5 clk = ~clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Transfer inhibit forces the update enable low
   function automatic logic [31:0] exp_b(input logic [7:0] w);
      return {24'h000000, w[7] ? (w & 8'hEF) : w};
   endfunction : exp_b

   function automatic logic [31:0] exp_osc(input logic [2:0] f);
      return (f[2:1] == 2'h1) ? 32'h00000003 : ((f[2:1] == 2'h3) ? 32'h00000002 : 32'h00000000);
   endfunction : exp_osc

   // Codes 1 and 2 reuse the slow 128 and 256 tick taps
   function automatic int exp_period(input int rs);
      return (rs == 1) ? 128 : ((rs == 2) ? 256 : (1 << (rs - 1)));
   endfunction : exp_period

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      host_u.xfer(1'b1, 1'b0, a, v, rd, er);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input string what, input logic [31:0] exp);
      host_u.xfer(1'b0, 1'b0, a, 8'h00, rd, er);
      chk(what, exp, rd);
   endtask : rdc

   task automatic wait_sig(input int sel, input int bound, output logic s);
      int n;
      n = 0;
      s = 1'b0;
      while (s !== 1'b1 && n < bound) begin
         @(posedge clk);
         n++;
         case (sel)
            0: s = irq_oe;
            1: s = busy;
            2: s = tcopy;
            default: s = dst_b;
         endcase
      end
   endtask : wait_sig

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   // Hang guard well beyond the half-second first update
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         wrap_up();
      end
   end

   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      por_b = 1'b0;
      pfail = 1'b0;
      bvalid = 1'b0;
      alarm = 1'b0;
      oct_day = 1'b0;
      apr_day = 1'b0;
      at_0159 = 1'b0;
      seed = 32'h0000AE16;
      err_count = 0;
      check_count = 0;
      cyc = 0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      por_b <= 1'b1;
      rdc(rtccs_pkg::REG_B_ADDR, "b_reset", 32'h00000000);
      rdc(rtccs_pkg::REG_C_ADDR, "c_reset", 32'h00000000);
      for (int v = 0; v < 2; v++) begin
         bvalid <= v[0];
         rdc(rtccs_pkg::REG_D_ADDR, "d_valid", {24'h000000, v[0], 7'h00});
      end
      $display("test reset values done");
      for (int i = 0; i < 6; i++) begin
         d = (i == 0) ? 8'hF0 : 8'(rnd());
         wr(rtccs_pkg::REG_B_ADDR, d);
         rdc(rtccs_pkg::REG_B_ADDR, "b_rw", exp_b(d));
         repeat (2) @(posedge clk);
         chk("hour_24", {31'h0, d[1]}, {31'h0, h24});
         chk("binary", {31'h0, d[2]}, {31'h0, bin});
      end
      wr(rtccs_pkg::REG_B_ADDR, 8'h00);
      for (int f = 0; f < 8; f++) begin
         d = {1'b1, f[2:0], 4'(rnd())};
         wr(rtccs_pkg::REG_A_ADDR, d);
         rdc(rtccs_pkg::REG_A_ADDR, "a_rw", {24'h000000, 1'b0, d[6:0]});
         repeat (2) @(posedge clk);
         chk("osc_div", exp_osc(f[2:0]), {30'h0, osc_run, div_run});
      end
      $display("test format and oscillator done");
      host_u.xfer(1'b0, 1'b0, rtccs_pkg::REG_C_ADDR, 8'h00, rd, er);
      wr(rtccs_pkg::REG_C_ADDR, 8'hFF);
      rdc(rtccs_pkg::REG_C_ADDR, "c_ro", 32'h00000000);
      wr(rtccs_pkg::REG_D_ADDR, 8'hFF);
      rdc(rtccs_pkg::REG_D_ADDR, "d_ro", 32'h00000080);
      host_u.xfer(1'b0, 1'b0, 8'h38, 8'h00, rd, er);
      chk("unmapped_err", 32'h00000001, {31'h0, er});
      host_u.xfer(1'b1, 1'b1, rtccs_pkg::REG_B_ADDR, 8'h0F, rd, er);
      rdc(rtccs_pkg::REG_B_ADDR, "ext_ignored", 32'h00000000);
      pfail <= 1'b1;
      wr(rtccs_pkg::REG_B_ADDR, 8'h06);
      rdc(rtccs_pkg::REG_B_ADDR, "pfail_block", 32'h00000000);
      chk("wprot_on", 32'h00000001, {31'h0, wprot});
      pfail <= 1'b0;
      wr(rtccs_pkg::REG_B_ADDR, 8'h06);
      rdc(rtccs_pkg::REG_B_ADDR, "recovery_block", 32'h00000000);
      repeat (20) @(posedge clk);
      chk("wprot_off", 32'h00000000, {31'h0, wprot});
      wr(rtccs_pkg::REG_B_ADDR, 8'h06);
      rdc(rtccs_pkg::REG_B_ADDR, "recovered", 32'h00000006);
      $display("test access and protection done");
      wr(rtccs_pkg::REG_A_ADDR, 8'h23);
      repeat (20) @(posedge clk);
      chk("pie_off_quiet", 32'h00000000, {31'h0, irq_oe});
      rdc(rtccs_pkg::REG_C_ADDR, "pf_no_irq_request_flag", 32'h00000040);
      wr(rtccs_pkg::REG_B_ADDR, 8'h40);
      foreach (rs_list[k]) begin
         wr(rtccs_pkg::REG_A_ADDR, 8'h20);
         host_u.xfer(1'b0, 1'b0, rtccs_pkg::REG_C_ADDR, 8'h00, rd, er);
         wr(rtccs_pkg::REG_A_ADDR, 8'h20 | rs_list[k][7:0]);
         wait_sig(0, 1500, hit);
         t0 = cyc;
         chk("irq_low", 32'h00000000, {31'h0, irq_n});
         rdc(rtccs_pkg::REG_C_ADDR, "pf_irq_request_flag", 32'h000000C0);
         wait_sig(0, 1500, hit);
         chk("period", exp_period(rs_list[k]) * CYC_TK, cyc - t0);
      end
      wr(rtccs_pkg::REG_A_ADDR, 8'h20);
      host_u.xfer(1'b0, 1'b0, rtccs_pkg::REG_C_ADDR, 8'h00, rd, er);
      rdc(rtccs_pkg::REG_C_ADDR, "c_cleared", 32'h00000000);
      chk("irq_released", 32'h00000001, {31'h0, irq_n, ~irq_oe} == 2'h3);
      $display("test periodic events done");
      wr(rtccs_pkg::REG_B_ADDR, 8'h47);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rdc(rtccs_pkg::REG_B_ADDR, "b_warm_reset", 32'h00000007);
      rdc(rtccs_pkg::REG_A_ADDR, "a_kept", 32'h00000020);
      wr(rtccs_pkg::REG_A_ADDR, 8'h00);
      alarm <= 1'b1;
      oct_day <= 1'b1;
      at_0159 <= 1'b1;
      wr(rtccs_pkg::REG_B_ADDR, 8'h37);
      wr(rtccs_pkg::REG_A_ADDR, 8'h20);
      t0 = cyc;
      repeat (32600) @(posedge clk);
      do begin
         host_u.xfer(1'b0, 1'b0, rtccs_pkg::REG_A_ADDR, 8'h00, rd, er);
         if (rd[7] !== 1'b1) last0 = cyc;
      end while (rd[7] !== 1'b1 && cyc < t0 + 33000);
      wait_sig(1, 100, hit);
      chk("uip_lead", 32'h00000001, {31'h0, (cyc - last0) >= rtccs_pkg::BUC_TICKS * CYC_TK});
      rdc(rtccs_pkg::REG_A_ADDR, "a_in_update", 32'h000000A0);
      wait_sig(2, 200, hit);
      chk("first_update", 32'h00000001, {31'h0, (cyc - t0) >= 32760 && (cyc - t0) <= 32776});
      // Daylight pulses share the update-end cycle of the copy pulse
      chk("fall_back", 32'h00000001, {31'h0, dst_b});
      chk("no_spring", 32'h00000000, {31'h0, dst_f});
      rdc(rtccs_pkg::REG_A_ADDR, "uip_cleared", 32'h00000020);
      rdc(rtccs_pkg::REG_C_ADDR, "update_flags", 32'h000000B0);
      $display("test update cycle done");
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
